/* logic/sysclk_pkg.sv */
// constants shared by the system clock generation control block
package sysclk_pkg;

  // ----------------------------------------------------------------
  // clock domains
  // ----------------------------------------------------------------
  localparam int NDOM      = 7;
  localparam int DOM_CORE  = 0;
  localparam int DOM_BUS   = 1;
  localparam int DOM_FLASH = 2;
  localparam int DOM_PA    = 3;
  localparam int DOM_PB    = 4;
  localparam int DOM_PC    = 5;
  localparam int DOM_PD    = 6;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_DIV    = 8'h00;
  localparam logic [7:0] OFF_OSC    = 8'h04;
  localparam logic [7:0] OFF_PLLMUL = 8'h08;
  localparam logic [7:0] OFF_SRC    = 8'h0c;
  localparam logic [7:0] OFF_MWAIT  = 8'h10;
  localparam logic [7:0] OFF_STOPA  = 8'h14;
  localparam logic [7:0] OFF_STOPD  = 8'h18;
  localparam logic [7:0] OFF_STAT   = 8'h1c;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int         DIV_FW      = 4;
  localparam logic [3:0] DIV_MAX     = 4'h6;
  localparam logic [27:0] DIV_RST    = 28'h0000000;
  localparam int         OSC_MAIN_B  = 0;
  localparam int         OSC_PLL_B   = 1;
  localparam logic [1:0] OSC_RST     = 2'h0;
  localparam int         MUL_W       = 6;
  localparam logic [5:0] MUL_MIN     = 6'h13;
  localparam logic [5:0] MUL_MAX     = 6'h3b;
  localparam logic [5:0] MUL_RST     = 6'h13;
  localparam logic [1:0] SEL_LOW_SPEED_ONCHIP_OSCILLATOR    = 2'h0;
  localparam logic [1:0] SEL_MAIN    = 2'h1;
  localparam logic [1:0] SEL_PLL     = 2'h2;
  localparam logic [1:0] SRC_RST     = 2'h0;
  localparam logic [0:0] MWAIT_RST   = 1'h0;
  localparam logic [31:0] STOPA_RST  = 32'h00000000;
  localparam logic [7:0] STOPD_RST   = 8'h00;
  localparam logic [31:0] STOPA_ALL  = 32'h29000000;
  localparam logic [7:0] STOPD_ALL   = 8'hff;
  localparam int         ST_MAIN_B   = 0;
  localparam int         ST_PLL_B    = 1;
  localparam int         ST_SRC_LO   = 2;
  localparam int         ST_READY_B  = 4;

  // ----------------------------------------------------------------
  // active clock source, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SRC_LOW_SPEED_ONCHIP_OSCILLATOR = 3'b001,
    SRC_MAIN = 3'b010,
    SRC_PLL  = 3'b100
  } sysclk_src_type;

endpackage

/* logic/sysclk_div.sv */
// power-of-two tick divider for one clock domain
`timescale 1ns/10ps
module sysclk_div
  import sysclk_pkg::*;
#(
  parameter int CW = 6
)
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          ce,
  // divider selection, divide by two to the power sel
  input  wire logic [3:0]    sel,
  // one-cycle tick per divided period
  output logic               tick
);

  generate
    if (CW < 1 || CW > 15)
    begin : g_bad_cw
      $error("sysclk_div: CW out of range");
    end
  endgenerate

  logic [CW-1:0] cnt;
  logic [CW-1:0] lim;
  logic          wrap;

  assign lim  = (CW'(1) << sel) - CW'(1);
  assign wrap = (cnt >= lim);

  // a shrinking sel never strands the counter above the limit
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      cnt  <= wrap ? '0 : cnt + CW'(1);
      tick <= wrap;
    end
  end

endmodule

/* logic/sysclk_ctrl.sv */
// system clock generation control: sources, pll, domain dividers, apb registers
`timescale 1ns/10ps

module sysclk_ctrl
  import sysclk_pkg::*;
#(
  parameter int CNT_W = 7
)
(
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  // oscillator and pll pins
  input  wire logic              main_osc_stable,
  input  wire logic              pll_locked,
  output logic                   main_osc_enable,
  output logic                   pll_enable,
  output logic [MUL_W-1:0]       pll_multiplier,
  output logic [2:0]             clock_source,
  // domain ticks
  output logic [NDOM-1:0]        domain_tick,
  output logic                   timer_count_tick,
  output logic                   timer_bus_tick,
  // memory wait and module stop
  output logic                   memory_wait_cycle_setting,
  output logic [31:0]            module_stop_a,
  output logic [7:0]             module_stop_d,
  output logic                   all_stop_ready
);

  generate
    if (CNT_W < 7 || CNT_W > 15)
    begin : g_bad_cnt_w
      $error("sysclk_ctrl: CNT_W cannot hold the largest divider");
    end
  endgenerate

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        hit;
  logic        acc;
  logic        wr;
  logic        wr_div;
  logic        wr_osc;
  logic        wr_mul;
  logic        wr_src;
  logic        div_ok;
  logic        mul_ok;
  logic [27:0] div_reg;
  logic [1:0]  osc_reg;
  logic [1:0]  src_sel;
  logic [31:0] next_rdata;

  assign hit = (paddr[1:0] == 2'h0) && (paddr <= OFF_STAT);
  assign acc = psel && penable && ce;
  assign wr  = acc && pwrite && hit;

  // a frozen block holds the bus rather than drop a write
  assign pready  = ce;
  assign pslverr = psel && penable && !hit;

  assign wr_div = wr && (paddr == OFF_DIV);
  assign wr_osc = wr && (paddr == OFF_OSC);
  assign wr_mul = wr && (paddr == OFF_PLLMUL);
  assign wr_src = wr && (paddr == OFF_SRC);

  // ----------------------------------------------------------------
  // write checks
  // ----------------------------------------------------------------
  always_comb
  begin
    div_ok = 1'b1;
    for (int i = 0; i < NDOM; i++)
    begin
      if (pwdata[i*DIV_FW +: DIV_FW] > DIV_MAX)
        div_ok = 1'b0;
    end
  end

  // factor is (field+1)/2, so ten to thirty in halves
  assign mul_ok = (pwdata[MUL_W-1:0] >= MUL_MIN) && (pwdata[MUL_W-1:0] <= MUL_MAX)
                  && (pwdata[31:MUL_W] == '0);

  // ----------------------------------------------------------------
  // divider register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      div_reg <= DIV_RST;
    else if (wr_div && div_ok)
      div_reg <= pwdata[27:0];
  end

  // ----------------------------------------------------------------
  // oscillator control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      osc_reg <= OSC_RST;
    else if (wr_osc)
      osc_reg <= pwdata[1:0];
  end

  assign main_osc_enable = osc_reg[OSC_MAIN_B];
  assign pll_enable      = osc_reg[OSC_PLL_B];

  // ----------------------------------------------------------------
  // pll multiplier
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pll_multiplier <= MUL_RST;
    else if (wr_mul && mul_ok)
      pll_multiplier <= pwdata[MUL_W-1:0];
  end

  // ----------------------------------------------------------------
  // source request, memory wait, module stop
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      src_sel <= SRC_RST;
    else if (wr_src && (pwdata[1:0] <= SEL_PLL))
      src_sel <= pwdata[1:0];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      memory_wait_cycle_setting <= MWAIT_RST;
    else if (wr && paddr == OFF_MWAIT)
      memory_wait_cycle_setting <= pwdata[0];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      module_stop_a <= STOPA_RST;
      module_stop_d <= STOPD_RST;
    end
    else if (wr && paddr == OFF_STOPA)
      module_stop_a <= pwdata;
    else if (wr && paddr == OFF_STOPD)
      module_stop_d <= pwdata[7:0];
  end

  // software must set these before asking for all-module stop
  assign all_stop_ready = ((module_stop_a & STOPA_ALL) == STOPA_ALL)
                          && ((module_stop_d & STOPD_ALL) == STOPD_ALL);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic       main_ok;
  logic       pll_ok;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end
    else if (ce)
    begin
      sync_a <= {sync_a[0], main_osc_stable};
      sync_b <= {sync_b[0], pll_locked};
    end
  end

  // a stable flag from a stopped source is not believed
  assign main_ok = sync_a[1] && osc_reg[OSC_MAIN_B];
  assign pll_ok  = sync_b[1] && osc_reg[OSC_PLL_B] && osc_reg[OSC_MAIN_B];

  // ----------------------------------------------------------------
  // active source: follows the request once the target is stable
  // ----------------------------------------------------------------
  sysclk_src_type active_src;
  sysclk_src_type next_src;

  always_comb
  begin
    next_src = active_src;
    unique case (active_src)
      SRC_LOW_SPEED_ONCHIP_OSCILLATOR,
      SRC_MAIN,
      SRC_PLL:
      begin
        if (src_sel == SEL_LOW_SPEED_ONCHIP_OSCILLATOR)
          next_src = SRC_LOW_SPEED_ONCHIP_OSCILLATOR;
        else if (src_sel == SEL_MAIN && main_ok)
          next_src = SRC_MAIN;
        else if (src_sel == SEL_PLL && pll_ok)
          next_src = SRC_PLL;
      end
      default:
        next_src = SRC_LOW_SPEED_ONCHIP_OSCILLATOR;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      active_src <= SRC_LOW_SPEED_ONCHIP_OSCILLATOR;
    else if (ce)
      active_src <= next_src;
  end

  assign clock_source = active_src;

  // ----------------------------------------------------------------
  // domain dividers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NDOM; g++)
    begin : g_dom
      sysclk_div #(
        .CW   (CNT_W)
      ) u_div (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .sel  (div_reg[g*DIV_FW +: DIV_FW]),
        .tick (domain_tick[g])
      );
    end
  endgenerate

  // timers count on one clock and talk to the bus on another
  assign timer_count_tick = domain_tick[DOM_PC];
  assign timer_bus_tick   = domain_tick[DOM_PA];

  // ----------------------------------------------------------------
  // read data, captured in the setup phase
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h00000000;
    unique case (paddr)
      OFF_DIV:    next_rdata = {4'h0, div_reg};
      OFF_OSC:    next_rdata = {30'h0, osc_reg};
      OFF_PLLMUL: next_rdata = {26'h0, pll_multiplier};
      OFF_SRC:    next_rdata = {30'h0, src_sel};
      OFF_MWAIT:  next_rdata = {31'h0, memory_wait_cycle_setting};
      OFF_STOPA:  next_rdata = module_stop_a;
      OFF_STOPD:  next_rdata = {24'h0, module_stop_d};
      OFF_STAT:   next_rdata = {27'h0, all_stop_ready,
                                (active_src == SRC_PLL) ? SEL_PLL :
                                (active_src == SRC_MAIN) ? SEL_MAIN : SEL_LOW_SPEED_ONCHIP_OSCILLATOR,
                                pll_ok, main_ok};
      default:    next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prdata <= 32'h00000000;
    else if (ce && psel && !penable)
      prdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_div_write;
    wr_div && div_ok;
  endsequence

  sequence s_bad_mul;
    wr_mul && !mul_ok;
  endsequence

  chk_source_slow_default: assert property (
    (src_sel == SEL_LOW_SPEED_ONCHIP_OSCILLATOR) && ce |=> (active_src == SRC_LOW_SPEED_ONCHIP_OSCILLATOR))
    else $error("source left the slow oscillator without request");

  chk_main_osc_write: assert property (
    $rose(main_osc_enable) |-> $past(wr_osc) && $past(pwdata[OSC_MAIN_B]))
    else $error("main oscillator started without a write");

  chk_mul_in_range: assert property (
    (pll_multiplier >= MUL_MIN) && (pll_multiplier <= MUL_MAX))
    else $error("pll multiplier out of range");

  chk_mul_bad_kept: assert property (
    s_bad_mul |=> $stable(pll_multiplier))
    else $error("bad pll multiplier accepted");

  chk_pll_by_write: assert property (
    $rose(src_sel == SEL_PLL) |-> $past(wr_src))
    else $error("pll requested without a write");

  chk_pll_switch_cause: assert property (
    $rose(active_src == SRC_PLL) |-> $past(src_sel == SEL_PLL) && $past(pll_ok))
    else $error("switch to pll without request and lock");

  chk_div_write_takes: assert property (
    s_div_write |=> (div_reg == $past(pwdata[27:0])))
    else $error("divider write lost");

  chk_div_bad_kept: assert property (
    wr_div && !div_ok |=> $stable(div_reg))
    else $error("illegal divider accepted");

  chk_timer_count_half: assert property (
    ce && $stable(div_reg) && div_reg[DOM_PC*DIV_FW +: DIV_FW] == 4'h1
    && timer_count_tick |=> !timer_count_tick)
    else $error("timer count tick not at the divided rate");

  chk_timer_bus_pa: assert property (
    ce ##1 (ce && $stable(div_reg) && div_reg[DOM_PA*DIV_FW +: DIV_FW] == 4'h0)
    |=> timer_bus_tick)
    else $error("timer bus tick missing at full rate");

endmodule

/* dv/tb.sv */
// self-checking testbench for the system clock generation control block
`timescale 1ns/10ps
module tb
  import sysclk_pkg::*;
  ;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              clk;
  logic              nrst;
  logic              ce;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic              pready;
  logic              pslverr;
  logic [31:0]       prdata;
  logic              main_osc_stable;
  logic              pll_locked;
  logic              main_osc_enable;
  logic              pll_enable;
  logic [MUL_W-1:0]  pll_multiplier;
  logic [2:0]        clock_source;
  logic [NDOM-1:0]   domain_tick;
  logic              timer_count_tick;
  logic              timer_bus_tick;
  logic              memory_wait_cycle_setting;
  logic [31:0]       module_stop_a;
  logic [7:0]        module_stop_d;
  logic              all_stop_ready;
  int                n_errors;
  int                checks;
  logic [31:0]       rd;
  logic              err;
  int                p;
  logic [NDOM-1:0]   tk;

  sysclk_ctrl #(.CNT_W(7)) dut
  (
    .clk(clk), .nrst(nrst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .main_osc_stable(main_osc_stable), .pll_locked(pll_locked),
    .main_osc_enable(main_osc_enable), .pll_enable(pll_enable),
    .pll_multiplier(pll_multiplier), .clock_source(clock_source),
    .domain_tick(domain_tick), .timer_count_tick(timer_count_tick),
    .timer_bus_tick(timer_bus_tick), .memory_wait_cycle_setting(memory_wait_cycle_setting),
    .module_stop_a(module_stop_a), .module_stop_d(module_stop_d),
    .all_stop_ready(all_stop_ready)
  );

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_n;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task automatic wait_src(input logic [2:0] exp);
    int k;
    k = 0;
    while (clock_source !== exp && k < 8)
    begin
      @(negedge clk);
      k++;
    end
    chk("clock_source", 32'(clock_source), 32'(exp));
  endtask

  // cycles between two ticks of one domain
  task automatic period(input int i, output int n);
    int k;
    k = 0;
    n = 0;
    do
    begin
      @(negedge clk);
      k++;
    end while (domain_tick[i] !== 1'b1 && k < 300);
    do
    begin
      @(negedge clk);
      n++;
    end while (domain_tick[i] !== 1'b1 && n < 300);
  endtask

  task automatic test_done;
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] rst_tab [8];
    logic [31:0] mw [6];
    logic [31:0] me [6];
    logic [1:0]  sc [4];
    logic [1:0]  se [4];
    logic [31:0] dv;
    rst_tab = '{32'h0, 32'h0, {26'h0, MUL_RST}, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    mw = '{32'h20, 32'h12, 32'h3c, 32'h13, 32'h3b, 32'h133};
    me = '{32'h20, 32'h20, 32'h20, 32'h13, 32'h3b, 32'h3b};
    sc = '{2'h1, 2'h2, 2'h3, 2'h0};
    se = '{2'h1, 2'h2, 2'h2, 2'h0};
    dv = 32'h05132610;
    n_errors = 0;
    checks = 0;
    nrst = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    main_osc_stable = 1'b0;
    pll_locked = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("clock_source", 32'(clock_source), 32'(SRC_LOW_SPEED_ONCHIP_OSCILLATOR));
    chk("main_osc_enable", 32'(main_osc_enable), 32'h0);
    chk("pll_multiplier", 32'(pll_multiplier), 32'(MUL_RST));
    for (int i = 0; i < 8; i++)
      rc("reset value", 8'(i * 4), rst_tab[i]);
    // stable pin alone must not let the main source in
    main_osc_stable <= 1'b1;
    wr(OFF_SRC, 32'h1);
    repeat (8) @(negedge clk);
    chk("clock_source", 32'(clock_source), 32'(SRC_LOW_SPEED_ONCHIP_OSCILLATOR));
    wr(OFF_SRC, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr(OFF_PLLMUL, mw[i]);
      rc("pll multiplier reg", OFF_PLLMUL, me[i]);
      chk("pll_multiplier", 32'(pll_multiplier), me[i]);
    end
    wr(OFF_OSC, 32'h3);
    pll_locked <= 1'b1;
    repeat (10) @(negedge clk);
    chk("clock_source", 32'(clock_source), 32'(SRC_LOW_SPEED_ONCHIP_OSCILLATOR));
    chk("osc enables", {30'h0, pll_enable, main_osc_enable}, 32'h3);
    rc("status", OFF_STAT, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_SRC, {30'h0, sc[i]});
      wait_src(3'(3'b001 << se[i]));
      rc("source reg", OFF_SRC, {30'h0, se[i]});
      rc("status", OFF_STAT, {28'h0, se[i], 2'h3});
    end
    wr(OFF_MWAIT, 32'h1);
    rc("wait reg", OFF_MWAIT, 32'h1);
    chk("memory wait", 32'(memory_wait_cycle_setting), 32'h1);
    // pc twice pa, pa twice pb, pb four times pd, core fastest
    wr(OFF_DIV, dv);
    wr(OFF_DIV, 32'h07000000);
    rc("divider reg", OFF_DIV, dv);
    for (int i = 0; i < NDOM; i++)
    begin
      period(i, p);
      chk("tick period", 32'(p), 32'h1 << dv[i*DIV_FW +: DIV_FW]);
    end
    repeat (64)
    begin
      @(negedge clk);
      chk("timer count tick", 32'(timer_count_tick), 32'(domain_tick[DOM_PC]));
      chk("timer bus tick", 32'(timer_bus_tick), 32'(domain_tick[DOM_PA]));
    end
    // a frozen block holds its state and stalls the bus
    @(posedge clk);
    ce <= 1'b0;
    fork
      wr(OFF_MWAIT, 32'h0);
      begin
        @(negedge clk);
        tk = domain_tick;
        repeat (6) @(negedge clk);
        chk("pready", 32'(pready), 32'h0);
        chk("frozen ticks", 32'(domain_tick), 32'(tk));
        chk("memory wait", 32'(memory_wait_cycle_setting), 32'h1);
        @(posedge clk);
        ce <= 1'b1;
      end
    join
    @(negedge clk);
    chk("memory wait", 32'(memory_wait_cycle_setting), 32'h0);
    wr(OFF_STOPD, 32'hff);
    wr(OFF_STOPA, 32'h28000000);
    @(negedge clk);
    chk("all stop ready", 32'(all_stop_ready), 32'h0);
    wr(OFF_STOPA, STOPA_ALL);
    @(negedge clk);
    chk("all stop ready", 32'(all_stop_ready), 32'h1);
    rc("status", OFF_STAT, 32'h13);
    wr(OFF_STOPD, 32'hfe);
    @(negedge clk);
    chk("all stop ready", 32'(all_stop_ready), 32'h0);
    // unmapped and misaligned places answer with an error and read zero
    apb(1'b1, 8'h20, 32'hffffffff);
    chk("pslverr", 32'(err), 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped read", rd, 32'h0);
    apb(1'b0, 8'h02, 32'h0);
    chk("pslverr", 32'(err), 32'h1);
    // second reset in mid-run
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("clock_source", 32'(clock_source), 32'(SRC_LOW_SPEED_ONCHIP_OSCILLATOR));
    chk("main_osc_enable", 32'(main_osc_enable), 32'h0);
    chk("pll_multiplier", 32'(pll_multiplier), 32'(MUL_RST));
    chk("all stop ready", 32'(all_stop_ready), 32'h0);
    test_done();
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done();
  end

endmodule
